// ---- logic/ccp_pkg.sv ----
// Constants, register map and decode helpers for the compare/PWM unit pair.
// Operation
// (RULE1) Compare data continuously checked against the first or third timer pair.
// (RULE2) Match drives pin high, low, toggles it, or leaves it, per mode field.
// (RULE3) Interrupt flag set in the same cycle as the match pin action.
// (RULE4) Writing zero to unit control forces compare output latch low only.
// (RULE5) Software clears the pin direction bit before using compare mode.
// (RULE6) Software runs the compare timer synchronously; async counting is unsupported.
// (RULE7) Mode 1010 only sets the interrupt flag, pin untouched.
// (RULE8) Mode 1011 pulses an internal special event trigger on match.
// (RULE9) Special event trigger resets the timer pair assigned to that unit.
// (RULE10) Second unit's trigger also starts A/D; converter must be enabled.
// (RULE11) Sixteen-bit data held as separately addressable low and high bytes.
// (RULE12) Pulse-width mode drives a modulated pin output of up to 10 bits.
// (RULE13) Software clears the direction bit to enable the modulated output driver.
// (RULE14) Clearing unit control to zero releases pin back to port logic.
// (RULE15) Ten-bit time base: 8-bit second timer plus two clock or prescaler bits.
// (RULE16) In pulse-width mode the data high byte is read-only.
// (RULE17) Period, duty, resolution come only from period, timer control, duty, control.
// (RULE18) After timer equals period: clear timer, set pin unless duty zero, latch duty.
// (RULE19) Pin cleared when time base equals buffered high byte and 2-bit latch.
// (RULE20) Timer select bits in third timer control choose each unit's time base.
// (RULE21) A match fires once when timer first equals compare value, no retrigger.
package ccp_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [ADDR_W-1:0] OFF_T3CTL = 8'h00;
  localparam logic [1:0][ADDR_W-1:0] OFF_LOW = {8'h10, 8'h04};
  localparam logic [1:0][ADDR_W-1:0] OFF_HIGH = {8'h14, 8'h08};
  localparam logic [1:0][ADDR_W-1:0] OFF_CTRL = {8'h18, 8'h0C};
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_T2CTL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_T2COUNT = 8'h28;
  // Control register implemented bits; second unit has bits 7:6 unimplemented
  localparam logic [1:0][7:0] CTRL_MASK = {8'h3F, 8'hFF};
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  // Field positions
  localparam int CTRL_FRAC_LO = 4;
  localparam int T3_SEL_A = 3;
  localparam int T3_SEL_B = 6;
  localparam int T2_ON = 2;
  // Mode field encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLR = 4'h9;
  localparam logic [3:0] MODE_SWI = 4'hA;
  localparam logic [3:0] MODE_SEV = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  // Second timer prescale selection
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  localparam logic [5:0] PS_LIM_1 = 6'h03;
  localparam logic [5:0] PS_LIM_4 = 6'h0F;
  localparam logic [5:0] PS_LIM_16 = 6'h3F;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic mode_is_pwm(input logic [3:0] m);
    return m[3:2] == MODE_PWM_TOP;
  endfunction

  function automatic logic mode_is_compare(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLR) ||
           (m == MODE_SWI) || (m == MODE_SEV);
  endfunction

  // First unit takes the third timer when select B is set, second when either is
  function automatic logic uses_third(input int unit, input logic [7:0] t3ctl);
    if (unit == 0) begin
      return t3ctl[T3_SEL_B];
    end
    return t3ctl[T3_SEL_B] | t3ctl[T3_SEL_A];
  endfunction
endpackage

// ---- logic/ccp_unit.sv ----
// One compare/PWM unit: match detection, output latch and PWM duty compare.
module ccp_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] mode_field,
  input wire logic [1:0] duty_fraction_bits,
  input wire logic ctrl_clear,
  input wire logic [15:0] cmp_value,
  input wire logic [15:0] timer_val,
  input wire logic [7:0] duty_new,
  input wire logic [7:0] duty_buf_hi,
  input wire logic period_end,
  input wire logic [9:0] time_base,
  output logic pin_ff,
  output logic own_ff,
  output logic match_evt,
  output logic sev_evt
);
  import ccp_pkg::*;

  logic eq_prev_ff;
  logic [1:0] frac_ff;
  logic is_pwm;
  logic is_cmp;
  logic eq_now;
  logic duty_clear_hit;
  logic duty_nonzero;

  // Decode and compare
  assign is_pwm = mode_is_pwm(mode_field);
  assign is_cmp = mode_is_compare(mode_field);
  // (RULE1) continuous pair compare
  assign eq_now = timer_val == cmp_value;
  // (RULE21) first-equal edge only
  assign match_evt = is_cmp & eq_now & ~eq_prev_ff;
  // (RULE8) trigger pulse in 1011
  assign sev_evt = match_evt & (mode_field == MODE_SEV);
  // (RULE19) duty end against buffer, time base given one edge ahead
  assign duty_clear_hit = time_base == {duty_buf_hi, frac_ff};
  assign duty_nonzero = {duty_new, duty_fraction_bits} != '0;

  // Equality history, kept in every mode so enabling compare never fires on a stale match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eq_prev_ff <= 1'b0;
    end else begin
      eq_prev_ff <= eq_now;
    end
  end

  // (RULE14) pin owned only while a driving mode is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_ff <= 1'b0;
    end else begin
      own_ff <= is_cmp | is_pwm;
    end
  end

  // Two-bit duty latch, loaded with the high byte at period end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frac_ff <= 2'h0;
    end else if (is_pwm && period_end) begin
      frac_ff <= duty_fraction_bits;
    end
  end

  // Output latch: zero-write clear first, then PWM, then compare actions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff <= 1'b0;
    end else if (ctrl_clear) begin
      // (RULE4) forced low on zero write
      pin_ff <= 1'b0;
    end else if (is_pwm) begin
      // (RULE18) period start sets pin
      if (period_end) begin
        pin_ff <= duty_nonzero;
      end else if (duty_clear_hit) begin
        // (RULE19) clear at duty match
        pin_ff <= 1'b0;
      end
    end else if (match_evt) begin
      // (RULE2) pin action by mode, (RULE7) 1010 and 1011 keep the pin
      case (mode_field)
        MODE_SET: pin_ff <= 1'b1;
        MODE_CLR: pin_ff <= 1'b0;
        MODE_TOGGLE: pin_ff <= ~pin_ff;
        default: pin_ff <= pin_ff;
      endcase
    end
  end
endmodule

// ---- logic/ccp_top.sv ----
// Two-unit compare/PWM block with second timer and AXI4-Lite register slave.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module ccp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ccp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] first_timer_pair,
  input wire logic [15:0] third_timer_pair,
  output logic [1:0] unit_output_pin,
  output logic [1:0] unit_pin_owned,
  output logic [1:0] unit_irq_flag,
  output logic reset_first_timer,
  output logic reset_third_timer,
  output logic adc_start
);
  import ccp_pkg::*;

  // Register file
  logic [7:0] t3ctl_ff;
  logic [1:0][7:0] low_ff;
  logic [1:0][7:0] high_ff;
  logic [1:0][7:0] ctrl_ff;
  logic [7:0] period_ff;
  logic [7:0] t2ctl_ff;
  logic [1:0] flag_ff;
  // Second timer
  logic [7:0] t2count_ff;
  logic [5:0] presc_ff;
  // AXI state
  logic aw_have_ff;
  logic w_have_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic sev_first_ff;
  logic sev_third_ff;
  logic adc_ff;

  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic nxt_aw_have;
  logic nxt_w_have;
  logic wr_hit;
  logic ar_hs;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [5:0] ps_lim;
  logic [1:0] ps_low;
  logic [5:0] nxt_presc;
  logic [7:0] nxt_t2count;
  logic t2_tick;
  logic period_end;
  logic [9:0] time_base;
  logic [1:0] match_evt;
  logic [1:0] sev_evt;
  logic [1:0] sel_third;
  logic [1:0] is_pwm;
  logic [1:0] wr_low;
  logic [1:0] wr_high;
  logic [1:0] wr_ctrl;
  logic [1:0] ctrl_clear;
  logic [1:0] pin_w;
  logic [1:0] own_w;

  // Write channel decode; writes land only when byte lane 0 is enabled
  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_lane0 = wr_go & wstrb_ff[0];
  assign wbyte = wdata_ff[7:0];
  assign nxt_aw_have = (aw_have_ff | aw_hs) & ~wr_go;
  assign nxt_w_have = (w_have_ff | w_hs) & ~wr_go;
  assign wr_hit = (waddr_ff == OFF_T3CTL) || (waddr_ff == OFF_PERIOD) ||
                  (waddr_ff == OFF_T2CTL) || (waddr_ff == OFF_STATUS) ||
                  (waddr_ff == OFF_T2COUNT) ||
                  (waddr_ff == OFF_LOW[0]) || (waddr_ff == OFF_HIGH[0]) ||
                  (waddr_ff == OFF_CTRL[0]) || (waddr_ff == OFF_LOW[1]) ||
                  (waddr_ff == OFF_HIGH[1]) || (waddr_ff == OFF_CTRL[1]);

  // Read decode; (RULE11) each data byte at its own offset
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign rd_byte = (s_axi_araddr == OFF_T3CTL) ? t3ctl_ff :
                   (s_axi_araddr == OFF_LOW[0]) ? low_ff[0] :
                   (s_axi_araddr == OFF_HIGH[0]) ? high_ff[0] :
                   (s_axi_araddr == OFF_CTRL[0]) ? ctrl_ff[0] :
                   (s_axi_araddr == OFF_LOW[1]) ? low_ff[1] :
                   (s_axi_araddr == OFF_HIGH[1]) ? high_ff[1] :
                   (s_axi_araddr == OFF_CTRL[1]) ? ctrl_ff[1] :
                   (s_axi_araddr == OFF_PERIOD) ? period_ff :
                   (s_axi_araddr == OFF_T2CTL) ? t2ctl_ff :
                   (s_axi_araddr == OFF_STATUS) ? {6'h00, flag_ff} :
                   (s_axi_araddr == OFF_T2COUNT) ? t2count_ff : 8'h00;
  assign rd_hit = (s_axi_araddr == OFF_T3CTL) || (s_axi_araddr == OFF_PERIOD) ||
                  (s_axi_araddr == OFF_T2CTL) || (s_axi_araddr == OFF_STATUS) ||
                  (s_axi_araddr == OFF_T2COUNT) ||
                  (s_axi_araddr == OFF_LOW[0]) || (s_axi_araddr == OFF_HIGH[0]) ||
                  (s_axi_araddr == OFF_CTRL[0]) || (s_axi_araddr == OFF_LOW[1]) ||
                  (s_axi_araddr == OFF_HIGH[1]) || (s_axi_araddr == OFF_CTRL[1]);

  // Write address and data are held independently until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awready_ff <= ~nxt_aw_have;
      wready_ff <= ~nxt_w_have;
    end
  end

  // Payload capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: one-cycle answer, address not accepted while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (!rvalid_ff || s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Shared registers; (RULE20) select bits and (RULE17) period and timer control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t3ctl_ff <= RST_BYTE;
      period_ff <= RST_PERIOD;
      t2ctl_ff <= RST_BYTE;
    end else if (wr_lane0) begin
      if (waddr_ff == OFF_T3CTL) begin
        t3ctl_ff <= wbyte;
      end
      if (waddr_ff == OFF_PERIOD) begin
        period_ff <= wbyte;
      end
      if (waddr_ff == OFF_T2CTL) begin
        t2ctl_ff <= wbyte;
      end
    end
  end

  // (RULE15) prescaler phase supplies the two low time base bits
  assign ps_lim = (t2ctl_ff[1:0] == PS_1) ? PS_LIM_1 :
                  (t2ctl_ff[1:0] == PS_4) ? PS_LIM_4 : PS_LIM_16;
  assign t2_tick = t2ctl_ff[T2_ON] & (presc_ff == ps_lim);
  assign period_end = t2_tick & (t2count_ff == period_ff);
  // (RULE18) cleared on the increment after it equals the period
  assign nxt_presc = !t2ctl_ff[T2_ON] ? presc_ff : t2_tick ? 6'h00 : presc_ff + 6'h01;
  assign nxt_t2count = !t2_tick ? t2count_ff : period_end ? 8'h00 : t2count_ff + 8'h01;
  // Time base one edge ahead, so the registered pin falls on the edge reaching the duty
  assign ps_low = (t2ctl_ff[1:0] == PS_1) ? nxt_presc[1:0] :
                  (t2ctl_ff[1:0] == PS_4) ? nxt_presc[3:2] : nxt_presc[5:4];
  assign time_base = {nxt_t2count, ps_low};

  // Second timer and its prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_ff <= 6'h00;
      t2count_ff <= 8'h00;
    end else begin
      presc_ff <= nxt_presc;
      t2count_ff <= nxt_t2count;
    end
  end

  // Per-unit registers and engines
  for (genvar u = 0; u < 2; u++) begin : g_unit
    assign is_pwm[u] = mode_is_pwm(ctrl_ff[u][3:0]);
    assign sel_third[u] = uses_third(u, t3ctl_ff);
    assign wr_low[u] = wr_lane0 & (waddr_ff == OFF_LOW[u]);
    assign wr_high[u] = wr_lane0 & (waddr_ff == OFF_HIGH[u]);
    assign wr_ctrl[u] = wr_lane0 & (waddr_ff == OFF_CTRL[u]);
    // (RULE4) zero write to the whole control register
    assign ctrl_clear[u] = wr_ctrl[u] & (wbyte == 8'h00);

    // Data bytes; (RULE18) duty copied to high byte, (RULE16) software write ignored
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        low_ff[u] <= RST_BYTE;
        high_ff[u] <= RST_BYTE;
      end else begin
        if (wr_low[u]) begin
          low_ff[u] <= wbyte;
        end
        if (is_pwm[u] && period_end) begin
          high_ff[u] <= low_ff[u];
        end else if (wr_high[u] && !is_pwm[u]) begin
          high_ff[u] <= wbyte;
        end
      end
    end

    // Control register, unimplemented bits read zero
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_ff[u] <= RST_BYTE;
      end else if (wr_ctrl[u]) begin
        ctrl_ff[u] <= wbyte & CTRL_MASK[u];
      end
    end

    // (RULE3) flag sets with the pin action; set beats a same-cycle clear
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_ff[u] <= 1'b0;
      end else if (match_evt[u]) begin
        flag_ff[u] <= 1'b1;
      end else if (wr_lane0 && waddr_ff == OFF_STATUS && wbyte[u]) begin
        flag_ff[u] <= 1'b0;
      end
    end

    ccp_unit u_unit (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode_field(ctrl_ff[u][3:0]),
      .duty_fraction_bits(ctrl_ff[u][CTRL_FRAC_LO+1:CTRL_FRAC_LO]),
      .ctrl_clear(ctrl_clear[u]),
      .cmp_value({high_ff[u], low_ff[u]}),
      .timer_val(sel_third[u] ? third_timer_pair : first_timer_pair),
      .duty_new(low_ff[u]),
      .duty_buf_hi(high_ff[u]),
      .period_end(period_end),
      .time_base(time_base),
      .pin_ff(pin_w[u]),
      .own_ff(own_w[u]),
      .match_evt(match_evt[u]),
      .sev_evt(sev_evt[u])
    );
  end

  // (RULE9) trigger resets the assigned timer; (RULE10) second unit starts A/D
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sev_first_ff <= 1'b0;
      sev_third_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else begin
      sev_first_ff <= |(sev_evt & ~sel_third);
      sev_third_ff <= |(sev_evt & sel_third);
      adc_ff <= sev_evt[1];
    end
  end

  // Port drive; (RULE12) modulated pin from the unit latch
  assign unit_output_pin = pin_w;
  assign unit_pin_owned = own_w;
  assign unit_irq_flag = flag_ff;
  assign reset_first_timer = sev_first_ff;
  assign reset_third_timer = sev_third_ff;
  assign adc_start = adc_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule

// ---- verif/ccp_top_checker.sv ----
// Port-level concurrent checks for the compare/PWM block
module ccp_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] unit_irq_flag,
  input wire logic reset_first_timer,
  input wire logic reset_third_timer,
  input wire logic adc_start
);
  import ccp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address channel refuses a second write until commit
  property p_aw_refuse;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("awready high after address taken");
  // Response two edges after both halves are taken together
  property p_b_timing;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_timing: assert property (p_b_timing) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_timing;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_timing: assert property (p_r_timing) else $error("read data late");
  // Bytes sit in the low lane; refused reads return zero
  property p_r_lane;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 &&
      (s_axi_rresp != RESP_SLVERR || s_axi_rdata == 32'h0000_0000);
  endproperty
  a_r_lane: assert property (p_r_lane) else $error("read data outside byte lane");
  // Trigger comes only in the same cycle as the flag of a match
  property p_trig_flag;
    reset_first_timer || reset_third_timer |-> unit_irq_flag != 2'h0;
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger without flag");
  property p_adc_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("conversion start not a pulse");
  // Conversion start travels with a timer reset
  property p_adc_reset;
    adc_start |-> reset_first_timer || reset_third_timer;
  endproperty
  a_adc_reset: assert property (p_adc_reset) else $error("start without timer reset");
  property p_first_once;
    reset_first_timer |=> !reset_first_timer;
  endproperty
  a_first_once: assert property (p_first_once) else $error("first timer reset repeated");
  property p_third_once;
    reset_third_timer |=> !reset_third_timer;
  endproperty
  a_third_once: assert property (p_third_once) else $error("third timer reset repeated");
  c_adc: cover property (adc_start);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_third: cover property (reset_third_timer && !adc_start);
endmodule

bind ccp_top ccp_top_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unit_irq_flag,
  .reset_first_timer, .reset_third_timer, .adc_start);

// ---- verif/ccp_timer_model.sv ----
// Behavioural first and third timer pairs seen by the compare units
module ccp_timer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr_req,
  input wire logic reset_first_timer,
  input wire logic reset_third_timer,
  output logic [15:0] first_timer_pair,
  output logic [15:0] third_timer_pair
);
  // synchronous counting, cleared by the trigger
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_req || reset_first_timer) first_timer_pair <= 16'h0000;
    else first_timer_pair <= first_timer_pair + 16'h0001;
    if (!aresetn || clr_req || reset_third_timer) third_timer_pair <= 16'h0000;
    else third_timer_pair <= third_timer_pair + 16'h0001;
  end
endmodule

// ---- verif/ccp_compare_and_pwm_core_tb_top.sv ----
// Self-checking bench for the compare/PWM block
module ccp_compare_and_pwm_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, tmr_clr = 1'b0;
  // Response ready held high throughout: the master never stalls answers
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, unit_output_pin, unit_pin_owned, unit_irq_flag;
  logic [31:0] s_axi_rdata;
  logic [15:0] first_timer_pair, third_timer_pair;
  logic reset_first_timer, reset_third_timer, adc_start;
  int error_cnt = 0, num_checks = 0, cyc = 0;

  ccp_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_timer_pair, .third_timer_pair, .unit_output_pin, .unit_pin_owned,
    .unit_irq_flag, .reset_first_timer, .reset_third_timer, .adc_start);
  ccp_timer_model tmr_u (.aclk, .aresetn, .clr_req(tmr_clr), .reset_first_timer,
    .reset_third_timer, .first_timer_pair, .third_timer_pair);

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well above the few thousand cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok |= s_axi_awvalid & s_axi_awready;
      w_ok |= s_axi_wvalid & s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, d, exp);
    chk("rresp", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk("outs", {unit_output_pin, unit_pin_owned, unit_irq_flag}, 32'h0000_0000);
    rd("period", OFF_PERIOD, 32'h0000_00FF);
    rd("ctrl1", OFF_CTRL[0], 32'h0000_0000);
    wr(OFF_LOW[0], 8'h34);
    wr(OFF_HIGH[0], 8'h12);
    rd("low1", OFF_LOW[0], 32'h0000_0034);
    rd("high1", OFF_HIGH[0], 32'h0000_0012);
    wr(OFF_CTRL[1], 8'hF0);
    rd("ctrl2", OFF_CTRL[1], 32'h0000_0030);
    wr(OFF_CTRL[1], 8'h00);
    axi_wr(8'h30, 8'h55, r);
    chk("wr_unmapped", 32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h30, d, r);
    chk("rd_unmapped", {d[29:0], r}, 32'(RESP_SLVERR));
  endtask

  // owned pin stands for a cleared direction bit; each mode but 1010 shows a pin change
  task automatic t_cmp();
    logic [3:0] md [4] = '{MODE_SET, MODE_CLR, MODE_TOGGLE, MODE_SWI};
    logic ep [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(OFF_LOW[0], 8'h40);
    wr(OFF_HIGH[0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL[0], {4'h0, md[i]});
      tmr_clr <= 1'b1;
      @(posedge aclk);
      tmr_clr <= 1'b0;
      do @(posedge aclk); while (unit_irq_flag[0] !== 1'b1);
      chk("match_time", 32'(first_timer_pair), 32'h0000_0041);
      chk("pin_action", 32'(unit_output_pin[0]), 32'(ep[i]));
      chk("owned", 32'(unit_pin_owned[0]), 32'h0000_0001);
      wr(OFF_STATUS, 8'h01);
      rd("flag_clear", OFF_STATUS, 32'h0000_0000);
    end
    wr(OFF_CTRL[0], 8'h00);
    @(posedge aclk);
    chk("zero_ctrl", 32'({unit_output_pin[0], unit_pin_owned[0]}), 32'h0000_0000);
  endtask

  // Unit, timer select and expected first, third, start pulses
  task automatic t_sev();
    int un [4] = '{0, 0, 1, 1};
    logic [7:0] t3 [4] = '{8'h00, 8'h40, 8'h08, 8'h00};
    logic [2:0] ex [4] = '{3'h4, 3'h2, 3'h3, 3'h5};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_T3CTL, t3[i]);
      wr(OFF_LOW[un[i]], 8'h20);
      wr(OFF_HIGH[un[i]], 8'h00);
      wr(OFF_CTRL[un[i]], {4'h0, MODE_SEV});
      tmr_clr <= 1'b1;
      @(posedge aclk);
      tmr_clr <= 1'b0;
      do @(posedge aclk); while ((reset_first_timer | reset_third_timer) !== 1'b1);
      chk("trigger", 32'({reset_first_timer, reset_third_timer, adc_start}), 32'(ex[i]));
      chk("sev_flag", 32'(unit_irq_flag[un[i]]), 32'h0000_0001);
      @(posedge aclk);
      chk("tmr_reset", 32'(ex[i][2] ? first_timer_pair : third_timer_pair), 32'h0000_0000);
      wr(OFF_CTRL[un[i]], 8'h00);
      wr(OFF_STATUS, 8'h03);
    end
    wr(OFF_T3CTL, 8'h00);
  endtask

  // Period 16 time base counts, duty 9, then zero duty, at each prescale
  task automatic t_pwm();
    int n;
    int k;
    for (int p = 0; p < 3; p++) begin
      k = 1 << (2 * p);
      wr(OFF_PERIOD, 8'h03);
      wr(OFF_LOW[0], 8'h02);
      wr(OFF_CTRL[0], 8'h1C);
      wr(OFF_T2CTL, {6'h01, 2'(p)});
      for (int z = 0; z < 2; z++) begin
        repeat (40 * k) @(posedge aclk);
        n = 0;
        repeat (32 * k) begin
          @(posedge aclk);
          n += int'(unit_output_pin[0] === 1'b1);
        end
        chk("high_time", 32'(n), 32'((z == 0) ? 18 * k : 0));
        wr(OFF_HIGH[0], 8'h77);
        rd("high_ro", OFF_HIGH[0], (z == 0) ? 32'h0000_0002 : 32'h0000_0000);
        wr(OFF_LOW[0], 8'h00);
        wr(OFF_CTRL[0], 8'h0C);
      end
      wr(OFF_T2CTL, 8'h00);
      wr(OFF_CTRL[0], 8'h00);
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_cmp();
    t_sev();
    t_pwm();
    wrap_up();
  end
endmodule
